// File: logic/mil_irq_ctrl.sv
// Local design decision: register access over AHB-Lite.
`timescale 1ns/10ps
module mil_irq_ctrl
  import mil_pkg::*;
(
  // Clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      ce,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [11:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic      [31:0]               hrdata,
  // CPU core
  input  wire logic                      instr_done,
  input  wire logic                      swi_exec,
  input  wire logic                      rti_exec,
  input  wire logic                      cli_exec,
  input  wire logic [7:0]                pulled_ccr,
  input  wire logic                      wait_mode,
  input  wire logic                      stop_mode,
  output logic                           stack_push,
  output logic                           stack_pull,
  output logic      [2:0]                stack_slot,
  output logic                           vector_fetch,
  output logic      [15:0]               vector_addr,
  output logic                           int_mask,
  output logic                           seq_busy,
  output logic                           wake_req,
  // Timer events
  input  wire logic                      capture_evt,
  input  wire logic                      compare_evt,
  input  wire logic                      overflow_evt,
  input  wire logic                      short_timer_zero,
  // Pins
  input  wire logic                      shared_led_int_pin_in,
  output logic                           shared_led_int_pin_out,
  output logic                           shared_led_int_pin_oe,
  input  wire logic [mil_pkg::KBD_N-1:0] keypad_pins,
  output logic      [7:0]                pullup_enable
);
  import mil_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  mil_seq_t    seq_ff;
  logic [2:0]  slot_ff;
  logic        mask_ff;
  logic [15:0] vec_ff;
  logic [7:0]  pullup_ff, kbd_en_ff, kbd_flag_ff, misc_ff, t8_ff;
  logic [7:0]  tmr_en_ff, tmr_flag_ff, tmr_arm_ff;
  logic        ext_latch_ff;
  logic        wr_ff;
  logic [7:0]  widx_ff;
  logic [31:0] rdata_ff;
  logic [4:0]  sync_lvl, sync_fall;
  logic        take, rd_take, wr_now;
  logic [7:0]  idx, wbyte, rbyte;
  logic        ext_en, ext_set, ext_clr;
  logic        req_ext, req_t16, req_t8, req_kbd, any_req;
  logic [15:0] sel_vec;
  logic        start_hw, start_sw, pin_low;
  logic [7:0]  kbd_clr, tmr_clr;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  mil_pin_sync #(.W(KBD_N + 1)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .pin_in  ({keypad_pins, shared_led_int_pin_in}),
    .level   (sync_lvl),
    .fall    (sync_fall)
  );

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;
  assign take      = hsel && hready && htrans[1] && ce;
  assign rd_take   = take && !hwrite;
  assign idx       = haddr[ADDR_LSB+7:ADDR_LSB];
  assign wr_now    = wr_ff && ce;
  assign wbyte     = hwdata[7:0];

  // Only whole-word transfers are expected; hsize is not checked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff   <= 1'b0;
      widx_ff <= RST_BYTE;
    end else if (ce) begin
      wr_ff   <= take && hwrite;
      widx_ff <= idx;
    end
  end

  always_comb begin
    rbyte = RST_BYTE;
    if (idx == IDX_PULLUP) begin
      rbyte = pullup_ff;
    end else if (idx == IDX_KBD_EN) begin
      rbyte = kbd_en_ff;
    end else if (idx == IDX_KBD_FLAGS) begin
      rbyte = kbd_flag_ff;
    end else if (idx == IDX_T8_CS) begin
      rbyte = t8_ff;
    end else if (idx == IDX_TMR_CTRL) begin
      rbyte = tmr_en_ff;
    end else if (idx == IDX_TMR_STAT) begin
      rbyte = tmr_flag_ff;
    end else if (idx == IDX_MISC) begin
      rbyte = misc_ff;
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_ff <= {24'h00_0000, rbyte};
    end
  end

  // ----------------------------------------
  // Plain registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pullup_ff <= RST_BYTE;
      kbd_en_ff <= RST_BYTE;
      misc_ff   <= RST_BYTE;
    end else if (wr_now) begin
      if (widx_ff == IDX_PULLUP) begin
        pullup_ff <= wbyte;
      end else if (widx_ff == IDX_KBD_EN) begin
        kbd_en_ff <= wbyte;
      end else if (widx_ff == IDX_MISC) begin
        // Watchdog enable sticks once set; reset flag only clears
        misc_ff <= (wbyte & MISC_RW_MASK)
                 | ((wbyte | misc_ff) & (8'h01 << MISC_COPON))
                 | (wbyte & misc_ff & (8'h01 << MISC_POR));
      end
    end
  end
  assign pullup_enable = pullup_ff;
  assign ext_en        = misc_ff[MISC_EXT_EN];

  // Timer enables keep their value across reset
  always_ff @(posedge hclk) begin
    if (wr_now && widx_ff == IDX_TMR_CTRL) begin
      tmr_en_ff <= wbyte;
    end
  end

  // ----------------------------------------
  // Shared LED / interrupt pin
  // ----------------------------------------
  // Open drain: only ever pulls low
  assign shared_led_int_pin_out = 1'b0;
  assign shared_led_int_pin_oe  = !ext_en && misc_ff[MISC_LED];
  assign pin_low = !sync_lvl[0];

  // ----------------------------------------
  // External request latch
  // ----------------------------------------
  assign ext_set = ext_en && (sync_fall[0]
                 || (!misc_ff[MISC_SENSE] && pin_low));
  assign ext_clr = vector_fetch && vec_ff == VEC_EXT;

  // Set wins over the vector-fetch clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_latch_ff <= 1'b0;
    end else if (ce) begin
      if (ext_set) begin
        ext_latch_ff <= 1'b1;
      end else if (ext_clr) begin
        ext_latch_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // 16-bit timer flags
  // ----------------------------------------
  always_comb begin
    tmr_clr = RST_BYTE;
    if (rd_take && idx == IDX_CAP_LO) begin
      tmr_clr[TMR_CAP] = tmr_arm_ff[TMR_CAP];
    end
    if (take && idx == IDX_CMP_LO) begin
      tmr_clr[TMR_CMP] = tmr_arm_ff[TMR_CMP];
    end
    if (take && idx == IDX_CNT_LO) begin
      tmr_clr[TMR_OVF] = tmr_arm_ff[TMR_OVF];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_flag_ff <= RST_BYTE;
      tmr_arm_ff  <= RST_BYTE;
    end else if (ce) begin
      tmr_flag_ff[TMR_CAP] <= capture_evt  || (tmr_flag_ff[TMR_CAP] && !tmr_clr[TMR_CAP]);
      tmr_flag_ff[TMR_CMP] <= compare_evt  || (tmr_flag_ff[TMR_CMP] && !tmr_clr[TMR_CMP]);
      tmr_flag_ff[TMR_OVF] <= overflow_evt || (tmr_flag_ff[TMR_OVF] && !tmr_clr[TMR_OVF]);
      if (rd_take && idx == IDX_TMR_STAT) begin
        tmr_arm_ff <= tmr_flag_ff;
      end else begin
        tmr_arm_ff <= tmr_arm_ff & ~tmr_clr;
      end
    end
  end

  // ----------------------------------------
  // 8-bit timer flag and enable
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t8_ff <= RST_BYTE;
    end else if (ce) begin
      t8_ff[T8_FLAG] <= short_timer_zero
                      || (t8_ff[T8_FLAG] && !(wr_now && widx_ff == IDX_T8_CS && wbyte[T8_FLAG]));
      if (wr_now && widx_ff == IDX_T8_CS) begin
        t8_ff[T8_IE] <= wbyte[T8_IE];
      end
    end
  end

  // ----------------------------------------
  // Keypad flags
  // ----------------------------------------
  assign kbd_clr = (wr_now && widx_ff == IDX_KBD_FLAGS) ? wbyte : RST_BYTE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kbd_flag_ff <= RST_BYTE;
    end else if (ce) begin
      // Edge wins over a write-one clear in the same cycle
      kbd_flag_ff[KBD_N-1:0] <= sync_fall[KBD_N:1]
                              | (kbd_flag_ff[KBD_N-1:0] & ~kbd_clr[KBD_N-1:0]);
    end
  end

  // ----------------------------------------
  // Request gating and priority
  // ----------------------------------------
  assign req_ext = ext_latch_ff && ext_en;
  assign req_t16 = |(tmr_flag_ff & tmr_en_ff
                   & ((8'h01 << TMR_CAP) | (8'h01 << TMR_CMP) | (8'h01 << TMR_OVF)));
  assign req_t8  = t8_ff[T8_FLAG] && t8_ff[T8_IE];
  assign req_kbd = |(kbd_flag_ff & kbd_en_ff);
  assign any_req = req_ext || req_t16 || req_t8 || req_kbd;

  always_comb begin
    sel_vec = VEC_KBD;
    if (req_ext) begin
      sel_vec = VEC_EXT;
    end else if (req_t16) begin
      sel_vec = VEC_T16;
    end else if (req_t8) begin
      sel_vec = VEC_T8;
    end
  end

  // Wait: any source; stop: only clock-free sources
  assign wake_req = (wait_mode && any_req)
                  || (stop_mode && (req_ext || req_kbd));

  // ----------------------------------------
  // Entry and return sequencer
  // ----------------------------------------
  assign start_sw = seq_ff == MIL_IDLE && swi_exec;
  assign start_hw = seq_ff == MIL_IDLE && instr_done && !mask_ff && any_req && !swi_exec;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_ff  <= MIL_IDLE;
      slot_ff <= 3'h0;
      vec_ff  <= VEC_SWI;
    end else if (ce) begin
      case (seq_ff)
        MIL_IDLE: begin
          slot_ff <= 3'h0;
          if (start_sw || start_hw) begin
            seq_ff <= MIL_PUSH;
            vec_ff <= start_sw ? VEC_SWI : sel_vec;
          end else if (rti_exec) begin
            seq_ff <= MIL_PULL;
          end
        end
        MIL_PUSH: begin
          slot_ff <= slot_ff + 3'h1;
          if (slot_ff == STACK_LAST) begin
            seq_ff <= MIL_MASK;
          end
        end
        MIL_MASK: seq_ff <= MIL_VEC;
        MIL_VEC:  seq_ff <= MIL_IDLE;
        MIL_PULL: begin
          slot_ff <= slot_ff + 3'h1;
          if (slot_ff == STACK_LAST) begin
            seq_ff <= MIL_IDLE;
          end
        end
        default: seq_ff <= MIL_IDLE;
      endcase
    end
  end

  // Mask comes up set after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_ff <= 1'b1;
    end else if (ce) begin
      if (seq_ff == MIL_MASK) begin
        mask_ff <= 1'b1;
      end else if (seq_ff == MIL_PULL && slot_ff == 3'h0) begin
        mask_ff <= pulled_ccr[CCR_I];
      end else if (cli_exec && seq_ff == MIL_IDLE) begin
        mask_ff <= 1'b0;
      end
    end
  end

  assign stack_push   = ce && seq_ff == MIL_PUSH;
  assign stack_pull   = ce && seq_ff == MIL_PULL;
  assign stack_slot   = slot_ff;
  assign vector_fetch = ce && seq_ff == MIL_VEC;
  assign vector_addr  = vec_ff;
  assign int_mask     = mask_ff;
  assign seq_busy     = seq_ff != MIL_IDLE;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_push5;
    stack_push [*5];
  endsequence
  sequence s_mask_vec;
    !stack_push ##1 (int_mask && vector_fetch);
  endsequence
  a_entry_order: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (start_sw || start_hw) |=> s_push5 ##1 s_mask_vec)
    else $error("entry sequence out of order");
  a_rti_mask: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (stack_pull && stack_slot == 3'h0) |=> int_mask == $past(pulled_ccr[CCR_I]))
    else $error("mask not restored on return");
  a_swi_always: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (seq_ff == MIL_IDLE && swi_exec) |=> stack_push ##5 vector_addr == VEC_SWI)
    else $error("software interrupt not taken");
  a_ext_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
    (start_hw && sel_vec == VEC_EXT) |-> (!mask_ff && ext_en))
    else $error("external taken while blocked");
  a_pin_role: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_en |-> !shared_led_int_pin_oe)
    else $error("pin driven while used as input");
  a_latch_clear: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (vector_fetch && vec_ff == VEC_EXT && !ext_set) |=> !ext_latch_ff)
    else $error("external latch kept after vector fetch");
  a_level_hold: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (ext_en && !misc_ff[MISC_SENSE] && pin_low) |=> ext_latch_ff)
    else $error("level request dropped");
  a_kbd_w1c: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (kbd_clr[0] && !sync_fall[1]) |=> !kbd_flag_ff[0])
    else $error("keypad flag not cleared");
  a_kbd_req: assert property (@(posedge hclk) disable iff (!hresetn)
    req_kbd == |(kbd_flag_ff[KBD_N-1:0] & kbd_en_ff[KBD_N-1:0]))
    else $error("keypad request mismatch");
  a_priority: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (start_hw && req_ext) |=> vector_addr == VEC_EXT)
    else $error("priority order violated");
endmodule

// File: logic/mil_pkg.sv
// Operation
// - Entry pushes registers, sets mask, loads vector
// - Return pulls registers including previous mask
// - Software interrupt ignores mask and enables
// - External interrupt blocked by mask or disable
// - Shared pin: LED when disabled, input when enabled
// - Check external latch after each instruction
// - Vector fetch clears external request latch
// - Sense bit: 0 edge+level, 1 edge only
// - Level mode keeps request while pin low
// - Edge mode needs high then low again
// - Reset clears whole misc control register
// - Capture flag and enable request timer interrupt
// - Compare flag and enable request timer interrupt
// - Overflow flag and enable request timer interrupt
// - 16-bit timer masked, wakes from wait
// - 8-bit timer zero requests, masked, wakes from wait
// - Pull-up enable bits, cleared at reset
// - Keypad falling edge sets flag; enable gates
// - Keypad flags write-one-clear; reset clears both
// - Keypad wakes from wait and stop
// - Priority external, 16-bit, 8-bit, keypad
// - Masked requests stay latched until unmasked
package mil_pkg;
  // ----------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [7:0] IDX_PULLUP     = 8'h0A;
  localparam logic [7:0] IDX_KBD_EN     = 8'h0B;
  localparam logic [7:0] IDX_KBD_FLAGS  = 8'h0C;
  localparam logic [7:0] IDX_T8_CS      = 8'h0D;
  localparam logic [7:0] IDX_TMR_CTRL   = 8'h12;
  localparam logic [7:0] IDX_TMR_STAT   = 8'h13;
  localparam logic [7:0] IDX_CAP_LO     = 8'h15;
  localparam logic [7:0] IDX_CMP_LO     = 8'h17;
  localparam logic [7:0] IDX_CNT_LO     = 8'h19;
  localparam logic [7:0] IDX_MISC       = 8'h1C;
  localparam int         ADDR_LSB       = 2;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MISC_EXT_EN  = 7;
  localparam int MISC_SENSE   = 6;
  localparam int MISC_LED     = 2;
  localparam int MISC_COPON   = 1;
  localparam int MISC_POR     = 0;
  localparam logic [7:0] MISC_RW_MASK = 8'hF4;
  localparam int TMR_CAP      = 7;
  localparam int TMR_CMP      = 6;
  localparam int TMR_OVF      = 5;
  localparam int T8_FLAG      = 7;
  localparam int T8_IE        = 6;
  localparam int CCR_I        = 3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ----------------------------------------
  // Vectors and stacking
  // ----------------------------------------
  localparam logic [15:0] VEC_SWI  = 16'h1FFC;
  localparam logic [15:0] VEC_EXT  = 16'h1FFA;
  localparam logic [15:0] VEC_T16  = 16'h1FF8;
  localparam logic [15:0] VEC_T8   = 16'h1FF6;
  localparam logic [15:0] VEC_KBD  = 16'h1FF4;
  localparam logic [2:0]  STACK_LAST = 3'h4;
  localparam int          KBD_N      = 4;
  typedef enum logic [2:0] {MIL_IDLE, MIL_PUSH, MIL_MASK, MIL_VEC, MIL_PULL} mil_seq_t;
endpackage

// File: logic/mil_pin_sync.sv
`timescale 1ns/10ps
module mil_pin_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  // Pins in
  input  wire logic [W-1:0] pin_in,
  // Cleaned outputs
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall
);
  // --------------------------------
  // Per-bit three-stage sampler
  // --------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff;
      // Idle high so nothing looks like a fall after reset
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_ff  <= 1'b1;
          s2_ff  <= 1'b1;
          s3_ff  <= 1'b1;
          lvl_ff <= 1'b1;
        end else if (ce) begin
          s1_ff <= pin_in[i];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            lvl_ff <= s3_ff;
          end
        end
      end
      assign level[i] = lvl_ff;
      assign fall[i]  = ce && lvl_ff && (s2_ff == s3_ff) && !s3_ff;
    end
  endgenerate
endmodule

// File: verif/mil_cpu_model.sv
`timescale 1ns/10ps
module mil_cpu_model (
  // Clock
  input  wire logic       hclk,
  // Sequencer side
  input  wire logic       stack_push,
  input  wire logic       stack_pull,
  input  wire logic [2:0] stack_slot,
  input  wire logic       int_mask,
  // Strobes and pin sources
  output logic      [3:0] strb,
  output logic      [7:0] pulled_ccr,
  output logic            ext_low,
  output logic      [3:0] kbd_low
);
  logic [7:0] ccr_ff;
  initial begin
    strb    = 4'h0;
    ext_low = 1'b0;
    kbd_low = 4'h0;
    ccr_ff  = 8'hE0;
  end
  // Last pushed slot is the CCR, taken before the mask rises
  always @(posedge hclk) if (stack_push === 1'b1 && stack_slot == 3'h4) ccr_ff <= {4'hE, int_mask, 3'h0};
  // Byte bus carries garbage outside the CCR pull slot
  assign pulled_ccr = (stack_pull === 1'b1 && stack_slot == 3'h0) ? ccr_ff : ~ccr_ff;
  task automatic pulse(input int k);
    @(posedge hclk);
    strb <= 4'(1 << k);
    @(posedge hclk);
    strb <= 4'h0;
  endtask
  // Sources only pull low; otherwise pins idle high on pull-ups
  task automatic pins(input logic e, input logic [3:0] k);
    @(posedge hclk);
    ext_low <= e;
    kbd_low <= k;
    repeat (6) @(posedge hclk);
  endtask
endmodule

// File: verif/mcu_interrupt_logic_bench.sv
`timescale 1ns/10ps
module mcu_interrupt_logic_bench;
  import mil_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, wait_mode, stop_mode;
  logic        stack_push, stack_pull, vector_fetch, int_mask, seq_busy, wake_req;
  logic        t8_zero, ovf_evt, pin_out, pin_oe, ext_low, ce, cap_evt, cmp_evt;
  logic [1:0]  htrans;
  logic [2:0]  stack_slot, hsize;
  logic [3:0]  strb, kbd_low;
  logic [7:0]  pulled_ccr, pullup_enable, rd;
  logic [11:0] haddr;
  logic [15:0] vector_addr;
  logic [31:0] hwdata, hrdata;
  int          err_count, checks, pushes;

  mil_irq_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .instr_done(strb[0]), .swi_exec(strb[1]), .rti_exec(strb[2]), .cli_exec(strb[3]),
    .pulled_ccr(pulled_ccr), .wait_mode(wait_mode), .stop_mode(stop_mode), .stack_push(stack_push),
    .stack_pull(stack_pull), .stack_slot(stack_slot), .vector_fetch(vector_fetch), .vector_addr(vector_addr),
    .int_mask(int_mask), .seq_busy(seq_busy), .wake_req(wake_req), .capture_evt(cap_evt), .compare_evt(cmp_evt),
    .overflow_evt(ovf_evt), .short_timer_zero(t8_zero), .shared_led_int_pin_in(~(pin_oe | ext_low)),
    .shared_led_int_pin_out(pin_out), .shared_led_int_pin_oe(pin_oe), .keypad_pins(~kbd_low),
    .pullup_enable(pullup_enable));
  mil_cpu_model u_cpu (.hclk(hclk), .stack_push(stack_push), .stack_pull(stack_pull), .stack_slot(stack_slot),
    .int_mask(int_mask), .strb(strb), .pulled_ccr(pulled_ccr), .ext_low(ext_low), .kbd_low(kbd_low));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(negedge hclk) if (stack_push === 1'b1) pushes++;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {2'h0, idx, 2'h0};
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
    chk({hrdata[31:24], hrdata[15:8]}, 16'h0000);
    chk({hrdata[23:16], 7'h00, hresp}, 16'h0000);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk({8'h0, rd}, {8'h0, exp});
  endtask
  task automatic svc(input int k, input logic [15:0] vec);
    int p0;
    p0 = pushes;
    u_cpu.pulse(k);
    for (int i = 0; i < 20 && vector_fetch !== 1'b1; i++) @(negedge hclk);
    chk(vector_addr, vec);
    chk({14'h0, seq_busy, int_mask}, 16'h3);
    chk(16'(pushes - p0), 16'h5);
  endtask
  task automatic nosvc();
    int p0;
    p0 = pushes;
    u_cpu.pulse(0);
    repeat (10) @(negedge hclk);
    chk(16'(pushes - p0), 16'h0);
  endtask
  task automatic ret(input logic m);
    u_cpu.pulse(2);
    repeat (8) @(negedge hclk);
    chk(16'(int_mask), 16'(m));
    chk(16'(seq_busy), 16'h0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdchk(IDX_MISC, 8'h00);
    rdchk(IDX_KBD_EN, 8'h00);
    rdchk(IDX_KBD_FLAGS, 8'h00);
    bus(1'b1, IDX_PULLUP, 8'hA5);
    rdchk(IDX_PULLUP, 8'hA5);
    chk({8'h0, pullup_enable}, 16'h00A5);
    bus(1'b1, IDX_MISC, 8'h30);
    rdchk(IDX_MISC, 8'h30);
    bus(1'b1, 8'h3F, 8'hFF);
    rdchk(8'h3F, 8'h00);
    @(posedge hclk) hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(IDX_MISC, 8'h00);
    rdchk(IDX_PULLUP, 8'h00);
  endtask
  task automatic t_swi();
    svc(1, VEC_SWI);
    ret(1'b1);
    u_cpu.pulse(3);
    svc(1, VEC_SWI);
    ret(1'b0);
  endtask
  task automatic t_ext();
    bus(1'b1, IDX_MISC, 8'h04);
    @(negedge hclk) chk({14'h0, pin_oe, pin_out}, 16'h2);
    nosvc();
    bus(1'b1, IDX_MISC, 8'hC4);
    @(negedge hclk) chk({14'h0, pin_oe, pin_out}, 16'h0);
    svc(1, VEC_SWI);
    u_cpu.pins(1'b1, 4'h0);
    nosvc();
    u_cpu.pulse(3);
    svc(0, VEC_EXT);
    u_cpu.pulse(3);
    nosvc();
    u_cpu.pins(1'b0, 4'h0);
    u_cpu.pins(1'b1, 4'h0);
    svc(0, VEC_EXT);
    bus(1'b1, IDX_MISC, 8'h80);
    u_cpu.pulse(3);
    svc(0, VEC_EXT);
    u_cpu.pulse(3);
    svc(0, VEC_EXT);
    u_cpu.pins(1'b0, 4'h0);
    bus(1'b1, IDX_MISC, 8'h00);
  endtask
  task automatic t_kbd();
    bus(1'b1, IDX_T8_CS, 8'h40);
    bus(1'b1, IDX_TMR_CTRL, 8'h20);
    bus(1'b1, IDX_KBD_EN, 8'h01);
    @(posedge hclk) {t8_zero, ovf_evt} <= 2'h3;
    @(posedge hclk) {t8_zero, ovf_evt, wait_mode} <= 3'h1;
    @(negedge hclk) chk(16'(wake_req), 16'h1);
    @(posedge hclk) {wait_mode, stop_mode} <= 2'h1;
    @(negedge hclk) chk(16'(wake_req), 16'h0);
    u_cpu.pins(1'b0, 4'h3);
    rdchk(IDX_KBD_FLAGS, 8'h03);
    @(negedge hclk) chk(16'(wake_req), 16'h1);
    @(posedge hclk) stop_mode <= 1'b0;
    u_cpu.pulse(3);
    svc(0, VEC_T16);
    rdchk(IDX_TMR_STAT, 8'h20);
    rdchk(IDX_CNT_LO, 8'h00);
    rdchk(IDX_TMR_STAT, 8'h00);
    rdchk(IDX_T8_CS, 8'hC0);
    u_cpu.pulse(3);
    svc(0, VEC_T8);
    bus(1'b1, IDX_T8_CS, 8'hC0);
    rdchk(IDX_T8_CS, 8'h40);
    u_cpu.pulse(3);
    svc(0, VEC_KBD);
    bus(1'b1, IDX_KBD_FLAGS, 8'h00);
    rdchk(IDX_KBD_FLAGS, 8'h03);
    bus(1'b1, IDX_KBD_FLAGS, 8'h01);
    rdchk(IDX_KBD_FLAGS, 8'h02);
    u_cpu.pulse(3);
    nosvc();
  endtask
  task automatic t_tmr();
    svc(1, VEC_SWI);
    bus(1'b1, IDX_TMR_CTRL, 8'hC0);
    @(posedge hclk) {cap_evt, cmp_evt, wait_mode} <= 3'h6;
    @(posedge hclk) {cap_evt, cmp_evt, wait_mode} <= 3'h1;
    @(negedge hclk) chk(16'(wake_req), 16'h1);
    @(posedge hclk) {wait_mode, stop_mode} <= 2'h1;
    @(negedge hclk) chk(16'(wake_req), 16'h0);
    @(posedge hclk) stop_mode <= 1'b0;
    rdchk(IDX_TMR_STAT, 8'hC0);
    nosvc();
    u_cpu.pulse(3);
    svc(0, VEC_T16);
    rdchk(IDX_CMP_LO, 8'h00);
    rdchk(IDX_TMR_STAT, 8'h80);
    rdchk(IDX_CAP_LO, 8'h00);
    rdchk(IDX_TMR_STAT, 8'h00);
  endtask
  // Clock enable low must freeze the sequencer and stall the bus
  task automatic t_freeze();
    int p0;
    p0 = pushes;
    @(posedge hclk) ce <= 1'b0;
    u_cpu.pulse(1);
    @(negedge hclk) chk(16'(hreadyout), 16'h0);
    @(posedge hclk) ce <= 1'b1;
    repeat (8) @(negedge hclk);
    chk(16'(pushes - p0), 16'h0);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Whole run is a few hundred cycles; this leaves a wide margin
  initial begin
    #3000000;
    err_count++;
    $display("CHECK FAILED at %0t: timeout", $time);
    test_done();
  end
  initial begin
    {hresetn, hsel, hwrite, wait_mode, stop_mode, t8_zero, ovf_evt, cap_evt, cmp_evt} = 9'h000;
    ce = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    haddr = 12'h000;
    hwdata = 32'h0000_0000;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    t_regs();
    t_swi();
    t_ext();
    t_kbd();
    t_tmr();
    t_freeze();
    test_done();
  end
endmodule
